// ---- bench/sci_meas_model.sv ----
/*
  Far-side model: measurement path answering step requests, plus a
  stream sink that stalls one cycle in three.
  Assumes MEAS_REQ stays high until the done pulse is taken.
*/
module sci_meas_model (
  input wire logic clk, // bench clock
  input wire logic req, // step request
  output logic done, // step done pulse
  output sci_pkg::sci_meas_res_t res, // step values
  output logic ready // sink ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import sci_pkg::*;
  int n = 0;
  int c = 0;
  // ****************
  // sink stall pattern
  // ****************
  always @(posedge clk) begin
    c <= c + 1;
    ready <= (c % 3) != 2;
  end
  // odd steps answer slowly and leave quasi-peak unmeasured
  initial begin
    done = 1'b0;
    res = '0;
    forever begin
      @(posedge clk);
      if (req === 1'b1) begin
        repeat ((n % 2) ? 4 : 1) @(posedge clk);
        res.taken <= (n % 2) ? 6'h3D : 6'h3F;
        for (int i = 0; i < 6; i++) begin
          res.val[16*i+:16] <= {4'h1, 4'(i), 8'(n)};
        end
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        res <= ~res; // no stale values once the pulse is over
        n++;
      end
    end
  end
endmodule

// ---- bench/sci_top_tb.sv ----
/*
  Self-checking bench: APB setup of the sweep command, error replies,
  one full sweep with stream compare, go while busy, and abort.
  Assumes the far-side model in sci_meas_model.
*/
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  errors++; $display("Error %s exp %h got %h", nm, e, g); end end
module sci_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sci_pkg::*;
  logic REF_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA;
  logic PREADY, PSLVERR, RF_READY = 1, MEAS_REQ, MEAS_DONE;
  logic TX_VALID, TX_READY, slv;
  sci_meas_cfg_t MEAS_CFG;
  sci_meas_res_t MEAS_RES;
  sci_tx_t TX, t;
  sci_tx_t q[$];
  int errors = 0, num_checks = 0, seed = 32'h3c0c, st, hold, k;
  logic [31:0] r, f;
  logic [15:0] v;
  logic [3:0] eidx[11] = '{R_START, R_STEP, R_DET0, R_DET0, R_HOLD,
    R_BWM, R_MATT, R_PAMP, R_PSEL, R_RBW, R_STOP};
  logic [31:0] eval[11] = '{32'h5, 32'h5, 32'h58, 32'h5153, 32'h7531,
    32'hFFFBFFFF, 32'h7, 32'h5858, 32'h5858, 32'h9, 32'h02000000};
  logic [7:0] ecode[11] = '{E_FREQ, E_STEP, E_DET, E_DET, E_HOLD,
    E_RBW, E_ATT, E_PAMP, E_PSEL, E_STEP20, E_RF};
  sci_top sci_top_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RF_READY(RF_READY), .MEAS_REQ(MEAS_REQ), .MEAS_CFG(MEAS_CFG),
    .MEAS_DONE(MEAS_DONE), .MEAS_RES(MEAS_RES), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .TX(TX));
  sci_meas_model sci_meas_model_i (.clk(REF_CLK), .req(MEAS_REQ),
    .done(MEAS_DONE), .res(MEAS_RES), .ready(TX_READY));
  // ****************
  // clock and stream monitor
  // ****************
  always #5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    if (TX_VALID === 1'b1 && TX_READY === 1'b1) q.push_back(TX);
  end
  // apb transfer; waits on pready, no assumed latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    slv = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // idle edge so a following call never re-drives psel in this step
    @(posedge REF_CLK);
  endtask
  task wr(input logic [3:0] i, input logic [31:0] d);
    apb(1'b1, 8'({i, 2'b00}), d);
  endtask
  // fields written in command order, valid defaults
  task cfg(input int span);
    wr(R_START, st);
    wr(R_STOP, st + span);
    wr(R_STEP, 32'h64);
    wr(R_DET0, 32'h5051);
    wr(R_DET1, 32'h0);
    wr(R_HOLD, hold);
    wr(R_RBW, 32'h2);
    wr(R_MATT, 32'hA);
    wr(R_PAMP, 32'h0066666F);
    wr(R_PSEL, 32'h4E4F);
    wr(R_SHOLD, 32'h0);
    wr(R_LIM, 32'h001E0000);
    wr(R_BWM, 32'hFFFFFFFF);
  endtask
  task pop();
    int w;
    w = 0;
    while (q.size() == 0 && w < 3000) begin
      @(posedge REF_CLK);
      w++;
    end
    if (q.size() == 0) t = '0;
    else t = q.pop_front();
  endtask
  // float of an integer, truncated
  function automatic logic [31:0] flt(input int x);
    int p;
    p = 0;
    for (int i = 0; i < 24; i++) if ((x >> i) & 1) p = i;
    return {1'b0, 8'(p + 127), 23'(x << (23 - p))};
  endfunction
  function automatic logic [15:0] ev(input int s, input int i);
    return (i == 1 && s % 2) ? 16'hC000 : {4'h1, 4'(i), 8'(s)};
  endfunction
  task wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    wrap_up();
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    st = 10 + ($unsigned($random(seed)) % 100000);
    hold = $unsigned($random(seed)) % 30001;
    apb(1'b0, 8'h3C, 32'h0);
    `CHK("unmapped err", 1'b1, slv)
    `CHK("unmapped data", 32'h0, r)
    // full sweep, two steps, letters given as QP
    cfg(100);
    apb(1'b0, 8'({R_START, 2'b00}), 32'h0);
    `CHK("start readback", st, r)
    wr(R_CTRL, 32'h1);
    pop();
    `CHK("ok reply", {K_RPL, E_OK}, t)
    f = flt(100);
    for (int b = 0; b < 32; b++) begin
      pop();
      `CHK("header", {K_HDR, (b < 4) ? f[8*b+:8] : 8'h00}, t)
    end
    for (k = 0; k < 2; k++) begin
      for (int i = 0; i < 2; i++) begin
        v = ev(k, i);
        pop();
        `CHK("data lo", {K_DAT, v[7:0]}, t)
        pop();
        `CHK("data hi", {K_DAT, v[15:8]}, t)
      end
    end
    pop();
    `CHK("end kind", K_END, t.kind)
    `CHK("meas cfg", {6'h03, 8'h0A, PA_OFF, 1'b1, 1'b1}, {MEAS_CFG.det, MEAS_CFG.min_att, MEAS_CFG.pamp, MEAS_CFG.presel, MEAS_CFG.att_auto})
    // one bad field per command; no sweep follows
    RF_READY <= 1'b0;
    for (int e = 0; e < 11; e++) begin
      cfg(100);
      wr(eidx[e], eval[e]);
      wr(R_CTRL, 32'h1);
      pop();
      `CHK("err reply", {K_RPL, ecode[e]}, t)
    end
    repeat (60) @(posedge REF_CLK);
    `CHK("no sweep", 0, q.size())
    // go while busy, then abort mid-sweep
    RF_READY <= 1'b1;
    cfg(1000);
    wr(R_CTRL, 32'h1);
    apb(1'b0, 8'({R_STAT, 2'b00}), 32'h0);
    `CHK("busy ok", {E_OK, 1'b1}, {r[15:8], r[0]})
    wr(R_CTRL, 32'h1);
    apb(1'b0, 8'({R_STAT, 2'b00}), 32'h0);
    `CHK("busy code", {E_GEN, 1'b1}, {r[15:8], r[0]})
    wr(R_CTRL, 32'h2);
    k = 0;
    do begin
      pop();
      k++;
    end while (t.kind !== K_ABT && t.kind !== K_END && k < 200);
    `CHK("abort ack", K_ABT, t.kind)
    repeat (20) @(posedge REF_CLK);
    `CHK("idle req", 1'b0, MEAS_REQ)
    wrap_up();
  end
endmodule

// ---- core/sci_pkg.sv ----
/*
  Shared definitions for the sweep command interpreter: register
  indices and fields, reply codes, limits, stream and measurement
  carriers, and small helper functions.
  Assumes an APB master with 32-bit data and 8-bit byte addresses.
*/
package sci_pkg;

  // ****************************************************
  // register indices (byte address is index times four)
  // ****************************************************
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_STAT = 4'h1;
  localparam logic [3:0] R_START = 4'h2;
  localparam logic [3:0] R_STOP = 4'h3;
  localparam logic [3:0] R_STEP = 4'h4;
  localparam logic [3:0] R_DET0 = 4'h5;
  localparam logic [3:0] R_DET1 = 4'h6;
  localparam logic [3:0] R_HOLD = 4'h7;
  localparam logic [3:0] R_RBW = 4'h8;
  localparam logic [3:0] R_MATT = 4'h9;
  localparam logic [3:0] R_PAMP = 4'hA;
  localparam logic [3:0] R_PSEL = 4'hB;
  localparam logic [3:0] R_SHOLD = 4'hC;
  localparam logic [3:0] R_LIM = 4'hD;
  localparam logic [3:0] R_BWM = 4'hE;
  localparam logic [3:0] R_LAST = 4'hE;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int C_GO = 0;
  localparam int C_ABORT = 1;
  localparam int S_BUSY = 0;
  localparam int S_CODE = 8;
  localparam int L_LIMIT = 0;
  localparam int L_TAB = 8;
  localparam int L_MAXATT = 16;
  localparam int BWM_QP = 16;

  // ****************************************************
  // reply codes and limits
  // ****************************************************
  localparam logic [7:0] E_OK = 8'h00;
  localparam logic [7:0] E_FREQ = 8'h01;
  localparam logic [7:0] E_STEP = 8'h02;
  localparam logic [7:0] E_DET = 8'h03;
  localparam logic [7:0] E_HOLD = 8'h04;
  localparam logic [7:0] E_RBW = 8'h05;
  localparam logic [7:0] E_ATT = 8'h06;
  localparam logic [7:0] E_PAMP = 8'h07;
  localparam logic [7:0] E_PSEL = 8'h08;
  localparam logic [7:0] E_STEP20 = 8'h14;
  localparam logic [7:0] E_GEN = 8'h65;
  localparam logic [7:0] E_RF = 8'h67;
  localparam logic [31:0] FREQ_MIN_HZ = 32'h0000000A;
  localparam logic [31:0] FREQ_MAX_HZ = 32'hB2D05E00;
  localparam logic [31:0] COND_MAX_HZ = 32'h01C9C380;
  localparam logic [31:0] STEP_MIN_HZ = 32'h0000000A;
  localparam logic [31:0] HOLD_MAX_MS = 32'h00007530;
  localparam logic [31:0] ATT_STEP_DB = 32'h00000005;
  localparam logic [7:0] TAB_MIN = 8'h02;
  localparam logic [15:0] NO_LEVEL = 16'hC000;
  localparam logic [4:0] HDR_LAST = 5'h1F;
  localparam logic [4:0] HDR_FLT = 5'h04;
  localparam logic [2:0] DET_LAST = 3'h5;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef enum logic [2:0] {
    K_RPL = 3'h0, K_HDR = 3'h1, K_DAT = 3'h2, K_END = 3'h3, K_ABT = 3'h4
  } sci_kind_t;
  typedef enum logic [1:0] {
    PA_OFF = 2'h0, PA_LD = 2'h1, PA_LN = 2'h2
  } sci_pamp_t;
  typedef struct packed {
    sci_kind_t kind;
    logic [7:0] data;
  } sci_tx_t;
  // det bits in output order: peak,qpeak,rms,avg,crms,cavg
  typedef struct packed {
    logic [31:0] freq;
    logic [5:0] det;
    logic smart;
    logic [31:0] hold_ms;
    logic [31:0] scan_hold_ms;
    logic [3:0] rbw;
    logic [7:0] min_att;
    logic att_auto;
    sci_pamp_t pamp;
    logic presel;
  } sci_meas_cfg_t;
  typedef struct packed {
    logic [5:0] taken;
    logic [95:0] val;
  } sci_meas_res_t;

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [7:0] sci_up(input logic [7:0] c);
    sci_up = (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
  endfunction

  // step chosen by the device for bandwidth indices 0 to 7; zero for the rest
  function automatic logic [31:0] sci_auto_step(input logic [3:0] r);
    case (r)
      4'h0: sci_auto_step = 32'h0000000A;
      4'h1: sci_auto_step = 32'h00000032;
      4'h2: sci_auto_step = 32'h00000064;
      4'h3: sci_auto_step = 32'h000001F4;
      4'h4: sci_auto_step = 32'h000003E8;
      4'h5: sci_auto_step = 32'h00001388;
      4'h6: sci_auto_step = 32'h00002710;
      4'h7: sci_auto_step = 32'h0000C350;
      default: sci_auto_step = 32'h00000000;
    endcase
  endfunction

  // unsigned integer to single float, truncating
  function automatic logic [31:0] sci_f32(input logic [31:0] v);
    logic [4:0] p;
    logic [31:0] m;
    p = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) p = 5'(i);
    end
    m = (p > 5'h17) ? v >> (p - 5'h17) : v << (5'h17 - p);
    sci_f32 = (v == 32'h00000000) ? 32'h00000000 :
              {1'b0, 8'(p) + 8'h7F, m[22:0]};
  endfunction

endpackage

// ---- core/sci_top.sv ----
/*
  Sweep command interpreter: APB register file holding the parsed
  sweep-setup command, parameter checker, sweep sequencer and byte
  stream of reply, header, detector values and end tokens.
  Assumes a measurement path that answers each step request with a
  one-cycle done pulse, and a byte sink with valid/ready.
*/

module sci_top (
  input wire logic REF_CLK, // 100 MHz clock
  input wire logic RST_N, // async reset, low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  input wire logic RF_READY, // radiated module ready
  output logic MEAS_REQ, // step request
  output sci_pkg::sci_meas_cfg_t MEAS_CFG, // step settings
  input wire logic MEAS_DONE, // step done pulse
  input wire sci_pkg::sci_meas_res_t MEAS_RES, // step values
  output logic TX_VALID, // stream byte valid
  input wire logic TX_READY, // stream sink ready
  output sci_pkg::sci_tx_t TX // stream token
);
  import sci_pkg::*;

  // ****************************************************
  // declarations
  // ****************************************************
  typedef enum logic [7:0] {
    ST_IDLE = 8'b00000001, ST_CHK = 8'b00000010, ST_RPL = 8'b00000100,
    ST_HDR = 8'b00001000, ST_REQ = 8'b00010000, ST_SND = 8'b00100000,
    ST_END = 8'b01000000, ST_ABT = 8'b10000000
  } sci_st_t;
  sci_st_t st;
  logic [31:0] regs [0:15];
  logic [3:0] idx;
  logic acc, wr, bad_addr, go, abort, sweeping, can_tx, hi;
  logic [7:0] code, chk;
  logic [4:0] bcnt;
  logic [2:0] di;
  logic [31:0] step, step_f, f_cur;
  logic [32:0] nf;
  logic [63:0] dstr;
  logic [5:0] mk, sel;
  logic smart, dbad, done, qp;
  logic [7:0] c;
  sci_meas_res_t res;
  sci_meas_cfg_t cfg;

  // ****************************************************
  // apb slave, zero wait states
  // ****************************************************
  assign idx = PADDR[5:2];
  assign acc = PSEL && PENABLE;
  assign bad_addr = (PADDR[7:6] != 2'h0) || (idx > R_LAST);
  assign wr = acc && PWRITE && !bad_addr;
  assign PREADY = 1'b1;
  assign PSLVERR = acc && bad_addr;
  assign go = wr && idx == R_CTRL && PWDATA[C_GO];
  assign abort = wr && idx == R_CTRL && PWDATA[C_ABORT];
  assign sweeping = st inside {ST_HDR, ST_REQ, ST_SND, ST_END};

  // parameter registers; control reads zero, status is live
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 16; i++) regs[i] <= 32'h00000000;
    end else if (wr && idx != R_CTRL && idx != R_STAT) begin
      regs[idx] <= PWDATA;
    end
  end

  always_comb begin
    PRDATA = 32'h00000000;
    if (acc && !PWRITE && !bad_addr) begin
      if (idx == R_STAT) begin
        PRDATA[S_BUSY] = st != ST_IDLE;
        PRDATA[S_CODE +: 8] = code;
      end else if (idx != R_CTRL) begin
        PRDATA = regs[idx];
      end
    end
  end

  // ****************************************************
  // parameter checker
  // ****************************************************
  assign dstr = {regs[R_DET1], regs[R_DET0]};
  assign step = sci_auto_step(regs[R_RBW][3:0]);
  // header float follows the accepted snapshot, not live registers
  assign step_f = sci_f32(sci_auto_step(cfg.rbw));

  // detector letters map to output-order bits
  always_comb begin
    mk = 6'h00;
    dbad = 1'b0;
    done = 1'b0;
    c = 8'h00;
    smart = sci_up(dstr[7:0]) == 8'h53;
    for (int i = 0; i < 8; i++) begin
      c = sci_up(dstr[8*i +: 8]);
      if (c == 8'h00) done = 1'b1;
      if (!done && !(smart && i == 0)) begin
        case (c)
          8'h50: begin
            mk[0] = 1'b1;
            dbad = dbad | smart;
          end
          8'h51: mk[1] = 1'b1;
          8'h52: mk[2] = 1'b1;
          8'h41: mk[3] = 1'b1;
          8'h4E: mk[4] = 1'b1;
          8'h43: mk[5] = 1'b1;
          default: dbad = 1'b1;
        endcase
      end
    end
    if (smart) begin
      mk[0] = 1'b1; // peak always taken in smart mode
      if (!regs[R_LIM][L_LIMIT] || mk[5:1] == 5'h00 ||
          $countones(mk[5:1]) > 1) dbad = 1'b1;
    end
    if (mk == 6'h00) dbad = 1'b1;
  end
  assign qp = mk[1];

  // first failing field wins, so exactly one reply
  always_comb begin
    chk = E_OK;
    if (regs[R_START] < FREQ_MIN_HZ || regs[R_STOP] > FREQ_MAX_HZ ||
        regs[R_START] > regs[R_STOP]) chk = E_FREQ;
    else if ((regs[R_STEP] != 32'h00000000 &&
              regs[R_STEP] < STEP_MIN_HZ) ||
             (regs[R_STEP] == 32'h00000000 &&
              regs[R_LIM][L_TAB +: 8] < TAB_MIN)) chk = E_STEP;
    else if (step < STEP_MIN_HZ) chk = E_STEP20;
    else if (dbad) chk = E_DET;
    else if ($signed(regs[R_HOLD]) < 0 ||
             regs[R_HOLD] > HOLD_MAX_MS) chk = E_HOLD;
    else if (regs[R_RBW] > 32'h0000000F ||
             !regs[R_BWM][regs[R_RBW][3:0]] ||
             (qp && !regs[R_BWM][BWM_QP + 32'(regs[R_RBW][3:0])]))
      chk = E_RBW;
    else if ($signed(regs[R_MATT]) < 0 ||
             regs[R_MATT] > 32'(regs[R_LIM][L_MAXATT +: 8]) ||
             regs[R_MATT] % ATT_STEP_DB != 32'h00000000)
      chk = E_ATT;
    else if (!(pamp_ok(regs[R_PAMP], 24'h004E4F) ||
               pamp_ok(regs[R_PAMP], 24'h004E4C) ||
               pamp_ok(regs[R_PAMP], 24'h46464F)))
      chk = E_PAMP;
    else if (!(pamp_ok(regs[R_PSEL], 24'h004E4F) ||
               pamp_ok(regs[R_PSEL], 24'h46464F)))
      chk = E_PSEL;
    else if (regs[R_STOP] > COND_MAX_HZ && !RF_READY)
      chk = E_RF;
  end

  // case-free match of a zero-terminated string of up to three chars
  function automatic logic pamp_ok(input logic [31:0] s,
                                   input logic [23:0] w);
    pamp_ok = sci_up(s[7:0]) == w[7:0] && sci_up(s[15:8]) == w[15:8] &&
              sci_up(s[23:16]) == w[23:16] && s[31:24] == 8'h00;
  endfunction

  // ****************************************************
  // sequencer
  // ****************************************************
  assign can_tx = !TX_VALID || TX_READY;
  // step from the snapshot so bus writes mid-sweep cannot bend it
  assign nf = {1'b0, f_cur} + {1'b0, sci_auto_step(cfg.rbw)};

  // abort overrides every sweep state at once
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= ST_IDLE;
    end else if (abort && sweeping) begin
      st <= ST_ABT;
    end else begin
      unique case (st)
        ST_IDLE: if (go) st <= ST_CHK;
        ST_CHK: st <= ST_RPL;
        ST_RPL: if (can_tx) st <= (code == E_OK) ? ST_HDR : ST_IDLE;
        ST_HDR: if (can_tx && bcnt == HDR_LAST) st <= ST_REQ;
        ST_REQ: if (MEAS_DONE) st <= ST_SND;
        ST_SND: if (can_tx && (!sel[di] || hi) && di == DET_LAST)
          st <= (nf > {1'b0, cfg.freq}) ? ST_END : ST_REQ;
        ST_END: if (can_tx) st <= ST_IDLE;
        ST_ABT: if (can_tx) st <= ST_IDLE;
      endcase
    end
  end

  // reply code; a go during a sweep is flagged as generic fault
  // only once sweeping, so a pending reply is never overwritten
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) code <= E_OK;
    else if (st == ST_CHK) code <= chk;
    else if (go && sweeping) code <= E_GEN;
  end

  // snapshot of checked settings, taken at every check; stop kept in freq field
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg <= '0;
      sel <= 6'h00;
    end else if (st == ST_CHK) begin
      cfg.freq <= regs[R_STOP];
      cfg.det <= mk;
      cfg.smart <= smart;
      cfg.hold_ms <= regs[R_HOLD];
      cfg.scan_hold_ms <= regs[R_SHOLD];
      cfg.rbw <= regs[R_RBW][3:0];
      cfg.min_att <= regs[R_MATT][7:0];
      cfg.att_auto <= 1'b1;
      cfg.pamp <= sci_up(regs[R_PAMP][7:0]) == 8'h4C ? PA_LN :
                  sci_up(regs[R_PAMP][15:8]) == 8'h4E ? PA_LD :
                  PA_OFF;
      cfg.presel <= sci_up(regs[R_PSEL][15:8]) == 8'h4E;
      sel <= mk;
    end
  end

  // step frequency walks from start to stop
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) f_cur <= 32'h00000000;
    else if (st == ST_CHK) f_cur <= regs[R_START];
    else if (st == ST_SND && can_tx && (!sel[di] || hi) && di == DET_LAST)
      f_cur <= nf[31:0];
  end

  // header byte count and detector walk position
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bcnt <= 5'h00;
      di <= 3'h0;
      hi <= 1'b0;
    end else begin
      if (st != ST_HDR) bcnt <= 5'h00;
      else if (can_tx) bcnt <= bcnt + 5'h01;
      if (st != ST_SND) begin
        di <= 3'h0;
        hi <= 1'b0;
      end else if (can_tx) begin
        hi <= sel[di] && !hi;
        if (!sel[di] || hi) di <= di + 3'h1;
      end
    end
  end

  // values captured once per step
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) res <= '0;
    else if (st == ST_REQ && MEAS_DONE) res <= MEAS_RES;
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign MEAS_REQ = st == ST_REQ;
  always_comb begin
    MEAS_CFG = cfg;
    MEAS_CFG.freq = f_cur;
  end

  // stream tokens, low byte first
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TX_VALID <= 1'b0;
      TX <= '0;
    end else if (can_tx) begin
      TX_VALID <= 1'b0;
      if (abort && sweeping) begin
        TX_VALID <= 1'b0;
      end else if (st == ST_RPL) begin
        TX_VALID <= 1'b1;
        TX <= '{K_RPL, code};
      end else if (st == ST_HDR) begin
        TX_VALID <= 1'b1;
        TX <= '{K_HDR, bcnt < HDR_FLT ?
                step_f[8*bcnt[1:0] +: 8] : 8'h00};
      end else if (st == ST_SND && sel[di]) begin
        TX_VALID <= 1'b1;
        TX <= '{K_DAT, res.taken[di] ? res.val[16*di + 8*hi +: 8] :
                NO_LEVEL[8*hi +: 8]};
      end else if (st == ST_END) begin
        TX_VALID <= 1'b1;
        TX <= '{K_END, 8'h00};
      end else if (st == ST_ABT) begin
        TX_VALID <= 1'b1;
        TX <= '{K_ABT, 8'h00};
      end
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  a_ok_starts_hdr: assert property (
    st == ST_RPL && code == E_OK && can_tx |=> st == ST_HDR &&
    TX_VALID && TX.kind == K_RPL && TX.data == E_OK)
    else $error("accepted command did not start header");
  a_err_no_sweep: assert property (
    st == ST_RPL && code != E_OK && can_tx |=> st == ST_IDLE &&
    TX.kind == K_RPL && TX_VALID)
    else $error("rejected command did not return to idle");
  a_freq_err_code: assert property (
    st == ST_CHK && regs[R_START] > regs[R_STOP] |=> code == E_FREQ)
    else $error("start above stop not code 1");
  a_hold_err_code: assert property (
    st == ST_RPL && code == E_HOLD |-> $signed(cfg.hold_ms) < 0 ||
    cfg.hold_ms > HOLD_MAX_MS)
    else $error("code 4 without bad hold time");
  a_hdr_len: assert property (
    st == ST_HDR && bcnt != HDR_LAST && !abort |=> st == ST_HDR)
    else $error("header cut short");
  a_no_level: assert property (
    st == ST_SND && can_tx && sel[di] && !res.taken[di] && !abort
    |=> TX.data == NO_LEVEL[8*$past(hi) +: 8])
    else $error("unmeasured value not marked");
  a_abort_now: assert property (
    abort && sweeping |=> st == ST_ABT ##[1:300] TX.kind == K_ABT)
    else $error("abort not taken at once");
  a_att_auto: assert property (
    MEAS_REQ |-> MEAS_CFG.att_auto &&
    MEAS_CFG.min_att % ATT_STEP_DB[7:0] == 8'h00)
    else $error("attenuator not automatic in sweep");
  a_tx_hold: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX))
    else $error("stream token changed while stalled");

  c_sweep_end: cover property (st == ST_END && can_tx);
  c_abort: cover property (st == ST_ABT && can_tx);
  c_err_reply: cover property (st == ST_RPL && code != E_OK);
  c_smart: cover property (MEAS_REQ && MEAS_CFG.smart);

endmodule
